//--- sai_defs.svh
// Register offsets, field positions, reset values and timing counts for the serial audio port
`ifndef SAI_DEFS_SVH
`define SAI_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SAI_OFF_FMT      8'h00
`define SAI_OFF_MASTER   8'h04
`define SAI_OFF_BDIV     8'h08
`define SAI_OFF_FDIV     8'h0c
`define SAI_OFF_STATUS   8'h10
`define SAI_OFF_LEFT     8'h14
`define SAI_OFF_RIGHT    8'h18
`define SAI_OFF_RATE     8'h1c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SAI_FMT_FMT_LSB  0
`define SAI_FMT_LEN_LSB  4
`define SAI_FMT_OFS_LSB  8
`define SAI_FMT_SW_BIT   16
`define SAI_MST_SEL_MASK 32'h0000_0031
`define SAI_LEN_RST      2'h2
`define SAI_BDIV_RST     7'h01
`define SAI_FDIV_RST     8'h40
`define SAI_STAT_CLKERR  0
`define SAI_STAT_FSYNC   1
`define SAI_STAT_BSYNC   2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAI_DRIFT_MAX    5
`define SAI_BAD_FRAMES   4
`define SAI_PLL_FS_RATIO 2048
`define SAI_DSP_FS_RATIO 1024
`define SAI_PLL_KHZ      98304

`endif

//--- sai_pkg.sv
// Types shared by the serial audio port modules
package sai_pkg;
  typedef enum logic [1:0] {SAI_I2S, SAI_LJ, SAI_RJ, SAI_TDM} sai_fmt_t;
  typedef enum logic [1:0] {SAI_W16, SAI_W20, SAI_W24, SAI_W32} sai_len_t;
endpackage : sai_pkg

//--- sai_clk_if.sv
// Master clock generator connection between the port and its divider
`timescale 1ns/100ps
interface sai_clk_if;
  logic       enable;
  logic [6:0] bit_div;
  logic [7:0] frame_div;
  logic       bit_clk;
  logic       frame_clk;
  modport ctrl (output enable, output bit_div, output frame_div,
                input bit_clk, input frame_clk);
  modport gen  (input enable, input bit_div, input frame_div,
                output bit_clk, output frame_clk);
endinterface : sai_clk_if

//--- sai_master_gen.sv
// Bit and frame clock divider used in master mode
`timescale 1ns/100ps
module sai_master_gen (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic mclk_tick,
  sai_clk_if.gen    cg
);
  import sai_pkg::*;
  `include "sai_defs.svh"

  logic [6:0] mdiv_reg;
  logic [7:0] bcnt_reg;

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  // Bit clock toggles every bit_div ticks; frame clock toggles every frame_div bit clock periods
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdiv_reg     <= 7'h00;
      bcnt_reg     <= 8'h00;
      cg.bit_clk   <= 1'b0;
      cg.frame_clk <= 1'b0;
    end else if (!cg.enable) begin
      mdiv_reg     <= 7'h00;
      bcnt_reg     <= 8'h00;
      cg.bit_clk   <= 1'b0;
      cg.frame_clk <= 1'b0;
    end else if (mclk_tick) begin
      if (mdiv_reg + 7'h01 >= cg.bit_div) begin
        mdiv_reg   <= 7'h00;
        cg.bit_clk <= ~cg.bit_clk;
        if (cg.bit_clk) begin
          if (bcnt_reg + 8'h01 >= cg.frame_div) begin
            bcnt_reg     <= 8'h00;
            cg.frame_clk <= ~cg.frame_clk;
          end else begin
            bcnt_reg <= bcnt_reg + 8'h01;
          end
        end
      end else begin
        mdiv_reg <= mdiv_reg + 7'h01;
      end
    end
  end
endmodule : sai_master_gen

//--- sai_port.sv
// Serial audio input port: format decode, clock checks and AHB-Lite registers
//
// Functional notes
// - Data sampled on bit clock rising edge.
// - Frame clock is word clock or frame sync.
// - Two-channel formats: 16-32 bits, 32/48/64 fs.
// - TDM frame rate and clock ratio limits.
// - Frame drift beyond five ticks forces resync.
// - Bad bit clock four frames forces resync; the code flags it on the fifth bad frame.
// - Format chosen by control register.
// - Reset format is I2S, 24 bits.
// - Master mode drives bit and frame clocks.
// - Two divider fields set master ratios.
// - RJ and TDM only under software control.
// - TDM frame starts at sync rising edge.
// - TDM data offset zero, one or N.
// - Right-justified: high is left channel.
// - PLL 2048x, processing 1024x sample rate.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`include "sai_defs.svh"
module sai_port #(
  parameter int FRAME_TOL = `SAI_DRIFT_MAX,
  parameter int BAD_LIMIT = `SAI_BAD_FRAMES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mclk_tick,
  input  wire logic        hw_mode,
  input  wire logic        bit_clk_in,
  input  wire logic        frame_clock_in,
  input  wire logic        serial_data_in,
  output logic             bit_clk_out,
  output logic             bit_clk_oe_b,
  output logic             frame_clock_out,
  output logic             frame_clock_oe_b,
  output logic      [31:0] left_sample,
  output logic      [31:0] right_sample,
  output logic             sample_valid,
  output logic             clock_error
);
  import sai_pkg::*;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  sai_fmt_t    fmt_reg;
  sai_len_t    len_reg;
  logic [4:0]  ofs_reg;
  logic        sw_reg;
  logic [31:0] mst_reg;
  logic [6:0]  bdiv_reg;
  logic [7:0]  fdiv_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] shift_reg;
  logic [5:0]  bitcnt_reg;
  logic [5:0]  want_reg;
  logic [15:0] mclk_cnt_reg;
  logic [15:0] mclk_ref_reg;
  logic        ref_ok_reg;
  logic [2:0]  bad_cnt_reg;
  logic [8:0]  bits_frame_reg;
  logic        fsync_err_reg;
  logic        bsync_err_reg;
  logic        bclk_d_reg;
  logic        fclk_d_reg;
  logic        cur_right_reg;
  logic        slot_reg;

  sai_clk_if cgi ();

  sai_master_gen u_gen (
    .clk       (clk),
    .rst_b     (rst_b),
    .mclk_tick (mclk_tick),
    .cg        (cgi.gen)
  );

  // Effective format: hardware pin mode falls back to two-channel formats
  function automatic sai_fmt_t eff_fmt(input sai_fmt_t f, input logic hw);
    eff_fmt = (hw && (f == SAI_RJ || f == SAI_TDM)) ? SAI_I2S : f;
  endfunction : eff_fmt

  function automatic logic [5:0] len_bits(input sai_len_t l);
    unique case (l)
      SAI_W16: len_bits = 6'd16;
      SAI_W20: len_bits = 6'd20;
      SAI_W24: len_bits = 6'd24;
      SAI_W32: len_bits = 6'd32;
    endcase
  endfunction : len_bits

  logic     master;
  sai_fmt_t fmt;
  logic     bclk;
  logic     fclk;
  logic     brise;
  logic     fedge;
  logic     frise;
  logic     resync;

  // Master select needs all three mode bits
  assign master      = (mst_reg & `SAI_MST_SEL_MASK) == `SAI_MST_SEL_MASK;
  assign fmt         = eff_fmt(fmt_reg, hw_mode);
  assign cgi.enable  = master;
  assign cgi.bit_div = bdiv_reg;
  assign cgi.frame_div = fdiv_reg;
  assign bclk        = master ? cgi.bit_clk : bit_clk_in;
  assign fclk        = master ? cgi.frame_clk : frame_clock_in;
  assign brise       = bclk && !bclk_d_reg;
  assign frise       = fclk && !fclk_d_reg;
  assign fedge       = (fmt == SAI_TDM) ? frise : (fclk != fclk_d_reg);
  assign resync      = fsync_err_reg || bsync_err_reg;

  // Pins driven only in master mode; enables are active low
  assign bit_clk_out      = cgi.bit_clk;
  assign frame_clock_out  = cgi.frame_clk;
  assign bit_clk_oe_b     = !master;
  assign frame_clock_oe_b = !master;
  assign clock_error      = resync;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Zero wait states; writes land in the data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_reg  <= SAI_I2S;
      len_reg  <= sai_len_t'(`SAI_LEN_RST);
      ofs_reg  <= 5'h00;
      sw_reg   <= 1'b0;
      mst_reg  <= 32'h0000_0000;
      bdiv_reg <= `SAI_BDIV_RST;
      fdiv_reg <= `SAI_FDIV_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `SAI_OFF_FMT: begin
          fmt_reg <= sai_fmt_t'(hwdata[`SAI_FMT_FMT_LSB +: 2]);
          len_reg <= sai_len_t'(hwdata[`SAI_FMT_LEN_LSB +: 2]);
          ofs_reg <= hwdata[`SAI_FMT_OFS_LSB +: 5];
        end
        `SAI_OFF_MASTER: mst_reg <= hwdata & `SAI_MST_SEL_MASK;
        `SAI_OFF_BDIV:   bdiv_reg <= hwdata[6:0];
        `SAI_OFF_FDIV:   fdiv_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered at the end of the address phase; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `SAI_OFF_FMT:    hrdata <= {15'h0000, hw_mode, 3'h0, ofs_reg, 2'h0,
                                    len_reg, 2'h0, fmt_reg};
        `SAI_OFF_MASTER: hrdata <= mst_reg;
        `SAI_OFF_BDIV:   hrdata <= {25'h0000000, bdiv_reg};
        `SAI_OFF_FDIV:   hrdata <= {24'h000000, fdiv_reg};
        `SAI_OFF_STATUS: hrdata <= {29'h00000000, bsync_err_reg, fsync_err_reg, resync};
        `SAI_OFF_LEFT:   hrdata <= left_sample;
        `SAI_OFF_RIGHT:  hrdata <= right_sample;
        // Fixed clock ratios so software can plan the clock tree
        `SAI_OFF_RATE:   hrdata <= {16'(`SAI_PLL_FS_RATIO),
                                    16'(`SAI_DSP_FS_RATIO)};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Clock checks
  // ----------------------------------------
  // Counts master ticks per frame; a change beyond tolerance means lost lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_d_reg    <= 1'b0;
      fclk_d_reg    <= 1'b0;
      mclk_cnt_reg  <= 16'h0000;
      mclk_ref_reg  <= 16'h0000;
      ref_ok_reg    <= 1'b0;
      fsync_err_reg <= 1'b0;
    end else begin
      bclk_d_reg <= bclk;
      fclk_d_reg <= fclk;
      if (frise) begin
        mclk_cnt_reg <= 16'h0000;
        mclk_ref_reg <= mclk_cnt_reg;
        ref_ok_reg   <= 1'b1;
        // One full frame of matching length clears the fault
        fsync_err_reg <= ref_ok_reg &&
          ((mclk_cnt_reg > mclk_ref_reg + 16'(FRAME_TOL)) ||
           (mclk_cnt_reg + 16'(FRAME_TOL) < mclk_ref_reg));
      end else if (mclk_tick && mclk_cnt_reg != 16'hffff) begin
        mclk_cnt_reg <= mclk_cnt_reg + 16'h0001;
      end
    end
  end

  // Bit clocks per frame must be 32, 48, 64 or 256 per frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bits_frame_reg <= 9'h000;
      bad_cnt_reg    <= 3'h0;
      bsync_err_reg  <= 1'b0;
    end else if (frise) begin
      bits_frame_reg <= 9'h000;
      if (bits_frame_reg == 9'd32 || bits_frame_reg == 9'd48 ||
          bits_frame_reg == 9'd64 || bits_frame_reg == 9'd256) begin
        bad_cnt_reg   <= 3'h0;
        bsync_err_reg <= 1'b0;
      end else if (bad_cnt_reg >= 3'(BAD_LIMIT)) begin
        bsync_err_reg <= 1'b1;
      end else begin
        bad_cnt_reg <= bad_cnt_reg + 3'h1;
      end
    end else if (brise && bits_frame_reg != 9'h1ff) begin
      bits_frame_reg <= bits_frame_reg + 9'h001;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Shifts MSB first; word ends when the chosen length is reached
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg     <= 32'h0000_0000;
      bitcnt_reg    <= 6'h00;
      want_reg      <= 6'h00;
      cur_right_reg <= 1'b0;
      slot_reg      <= 1'b0;
      left_sample   <= 32'h0000_0000;
      right_sample  <= 32'h0000_0000;
      sample_valid  <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (fedge) begin
        bitcnt_reg <= 6'h00;
        slot_reg   <= 1'b0;
        // Skip bits so the first data bit lines up with the format
        unique case (fmt)
          SAI_I2S: want_reg <= 6'd1;
          SAI_LJ:  want_reg <= 6'd0;
          // Half of the full frame count at frame start, running half frame count at mid-frame edge
          SAI_RJ:  want_reg <= 6'(frise ? bits_frame_reg[8:1] : bits_frame_reg) -
                               len_bits(len_reg);
          SAI_TDM: want_reg <= {1'b0, ofs_reg};
        endcase
        // RJ inverts the channel sense
        cur_right_reg <= (fmt == SAI_RJ) ? !fclk : fclk;
      end else if (brise) begin
        if (want_reg != 6'h00) begin
          want_reg <= want_reg - 6'h01;
        end else if (bitcnt_reg < len_bits(len_reg)) begin
          shift_reg  <= {shift_reg[30:0], serial_data_in};
          bitcnt_reg <= bitcnt_reg + 6'h01;
          if (bitcnt_reg + 6'h01 == len_bits(len_reg)) begin
            sample_valid <= 1'b1;
            // Left aligned in 32 bits; zeros while resync is pending
            if (resync) begin
              left_sample  <= 32'h0000_0000;
              right_sample <= 32'h0000_0000;
            end else if (fmt == SAI_TDM ? slot_reg : cur_right_reg) begin
              right_sample <= {shift_reg[30:0], serial_data_in} << (6'd32 - len_bits(len_reg));
            end else begin
              left_sample  <= {shift_reg[30:0], serial_data_in} << (6'd32 - len_bits(len_reg));
            end
            // TDM carries the second slot right behind the first
            if (fmt == SAI_TDM && !slot_reg) begin
              slot_reg   <= 1'b1;
              bitcnt_reg <= 6'h00;
            end
          end
        end
      end
    end
  end
endmodule : sai_port

//--- sai_port_checker.sv
// Pin-level assertions for the serial audio port
`timescale 1ns/100ps
`include "sai_defs.svh"
module sai_port_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        hw_mode,
  input wire logic        bit_clk_oe_b,
  input wire logic        frame_clock_oe_b,
  input wire logic [31:0] left_sample,
  input wire logic [31:0] right_sample,
  input wire logic        sample_valid,
  input wire logic        clock_error
);
  logic rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read request taken on this edge
  assign rd = hsel && htrans[1] && hready && !hwrite;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  valid_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("sample valid longer than a cycle");
  zero_on_err_a: assert property (clock_error && sample_valid |-> !left_sample && !right_sample)
    else $error("nonzero sample during resync");
  err_hold_a: assert property ($rose(clock_error) |-> clock_error [*8])
    else $error("resync ended too soon");
  oe_pair_a: assert property (bit_clk_oe_b == frame_clock_oe_b)
    else $error("clock enables disagree");
  unmapped_rd_a: assert property (rd && haddr == 32'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  status_rd_a: assert property (rd && haddr == `SAI_OFF_STATUS |=> hrdata[0] == $past(clock_error))
    else $error("status error bit wrong");
  hw_flag_a: assert property (rd && haddr == `SAI_OFF_FMT |=> hrdata[16] == $past(hw_mode))
    else $error("hardware mode flag wrong");
  cover property (sample_valid && !clock_error);
  cover property ($rose(clock_error));
  cover property (!bit_clk_oe_b);
endmodule : sai_port_checker
bind sai_port sai_port_checker chk_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .hw_mode, .bit_clk_oe_b, .frame_clock_oe_b, .left_sample,
  .right_sample, .sample_valid, .clock_error);

//--- sai_src_model.sv
// Behavioural audio source driving the slave-mode pins
`timescale 1ns/100ps
module sai_src_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [1:0]  fmt,
  input  wire logic [5:0]  len,
  input  wire logic [4:0]  ofs,
  input  wire logic [8:0]  bpf,
  input  wire logic [4:0]  stretch,
  input  wire logic [31:0] lw,
  input  wire logic [31:0] rw,
  output logic             bclk,
  output logic             fclk,
  output logic             sdata
);
  int          i, bi, pos, ch, half;
  logic [31:0] w;
  // ----------------------------------------
  // Frame generator, bits change while bit clock low
  // ----------------------------------------
  initial begin
    bclk = 1'b0;
    fclk = 1'b0;
    sdata = 1'b0;
    forever begin
      @(posedge clk);
      // Idle: clock still, data wanders so stale bits never match
      if (!run) begin
        bclk <= 1'b0;
        sdata <= 1'($urandom);
      end
      half = bpf / 2;
      for (i = 0; run && i < bpf; i++) begin
        if (fmt == 2'h3) begin
          bi = i - ofs;
          ch = (bi < 0) ? 2 : bi / len;
          pos = bi - ch * len;
          fclk <= (i == 0);
        end else begin
          ch = i / half;
          pos = i % half - ((fmt == 2'h0) ? 1 : (fmt == 2'h1) ? 0 : half - len);
          fclk <= (fmt == 2'h2) ? !ch[0] : ch[0];
        end
        w = ch[0] ? rw : lw;
        bclk <= 1'b0;
        sdata <= (ch < 2 && pos >= 0 && pos < len) ? w[len - 1 - pos] : 1'($urandom);
        repeat (4) @(posedge clk);
        bclk <= 1'b1;
        repeat ((i == bpf - 1) ? 4 + stretch : 4) @(posedge clk);
      end
    end
  end
endmodule : sai_src_model

//--- testbench.sv
// Self-checking bench for the serial audio port
`timescale 1ns/100ps
`include "sai_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  import sai_pkg::*;
  logic        clk, rst_b, hsel, hwrite, hw_mode, run, hrdy, hresp, bclk, fclk, sd;
  logic        bco, bcoe, fco, fcoe, vld, cerr, bpin, fpin;
  logic [31:0] haddr, hwdata, hrdata, lw, rw, lsmp, rsmp, rv;
  logic [1:0]  htrans, fmt;
  logic [5:0]  len;
  logic [4:0]  ofs, stretch;
  logic [8:0]  bpf;
  int          error_cnt, n_tests, k;
  int          tf[5] = '{0, 1, 2, 3, 3};
  int          tl[5] = '{24, 32, 16, 24, 20};
  int          tc[5] = '{2, 3, 0, 2, 1};
  int          to[5] = '{0, 0, 0, 0, 1};
  // Pin level from both drivers
  assign bpin = bcoe ? bclk : bco;
  assign fpin = fcoe ? fclk : fco;
  sai_port dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .mclk_tick(1'b1), .hw_mode(hw_mode),
    .bit_clk_in(bpin), .frame_clock_in(fpin), .serial_data_in(sd), .bit_clk_out(bco),
    .bit_clk_oe_b(bcoe), .frame_clock_out(fco), .frame_clock_oe_b(fcoe),
    .left_sample(lsmp), .right_sample(rsmp), .sample_valid(vld), .clock_error(cerr));
  sai_src_model src_u (.clk(clk), .run(run), .fmt(fmt), .len(len), .ofs(ofs), .bpf(bpf),
    .stretch(stretch), .lw(lw), .rw(rw), .bclk(bclk), .fclk(fclk), .sdata(sd));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    d = hrdata;
  endtask : bus
  task automatic rdchk(input logic [31:0] a, e, input string nm);
    bus(1'b0, a, 32'h0, rv);
    `CHK(nm, e, rv)
  endtask : rdchk
  // Bounded wait on valid (w=0) or error (w=1), sampled mid-cycle
  task automatic waitv(input int w, input logic v, input int lim, input string nm);
    int t;
    t = 0;
    do @(negedge clk); while ((w ? cerr : vld) !== v && ++t < lim);
    `CHK(nm, v, (w ? cerr : vld))
  endtask : waitv
  // Model words, left-aligned by the port
  task automatic stream(input logic [1:0] f, input int l, o, b);
    lw <= $urandom & (32'hffff_ffff >> (32 - l));
    rw <= $urandom & (32'hffff_ffff >> (32 - l));
    fmt <= f; len <= 6'(l); ofs <= 5'(o); bpf <= 9'(b); run <= 1'b1;
    // Settle past the frames disturbed by the switch and their drift flags
    repeat (12) waitv(0, 1'b1, 9000, "valid");
    waitv(1, 1'b0, 40000, "resync");
    repeat (2) waitv(0, 1'b1, 9000, "valid");
    `CHK("no resync", 1'b0, cerr)
    `CHK("left", lw << (32 - l), lsmp)
    `CHK("right", rw << (32 - l), rsmp)
    $display("test done: format %0d length %0d", f, l);
  endtask : stream
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  always #4 clk = ~clk;
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 0; rst_b = 0; hsel = 0; hwrite = 0; hw_mode = 0; run = 0; haddr = 0; hwdata = 0;
    htrans = 0; fmt = 0; len = 24; ofs = 0; bpf = 64; stretch = 0; lw = 0; rw = 0;
    error_cnt = 0; n_tests = 0;
    rv = $urandom(28);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(`SAI_OFF_FMT, 32'h20, "fmt reset");
    rdchk(`SAI_OFF_BDIV, 32'h1, "bdiv reset");
    rdchk(`SAI_OFF_FDIV, 32'h40, "fdiv reset");
    rdchk(`SAI_OFF_RATE, 32'h0800_0400, "rates");
    rdchk(32'h20, 32'h0, "unmapped");
    // Every format and word length, TDM offsets zero and one
    for (k = 0; k < 5; k++) begin
      rv = 32'(tf[k]) | (32'(tc[k]) << 4) | (32'(to[k]) << 8);
      bus(1'b1, `SAI_OFF_FMT, rv, lw);
      rdchk(`SAI_OFF_FMT, rv, "fmt");
      stream(2'(tf[k]), tl[k], to[k], (tf[k] == 3) ? 256 : 64);
    end
    // Pin configuration ignores right-justified select
    @(posedge clk);
    hw_mode <= 1'b1;
    bus(1'b1, `SAI_OFF_FMT, 32'h22, rv);
    bus(1'b0, `SAI_OFF_FMT, 32'h0, rv);
    `CHK("hw flag", 1'b1, rv[16])
    stream(2'h0, 24, 0, 64);
    @(posedge clk);
    hw_mode <= 1'b0;
    // Frame drift beyond tolerance, then bad bit clock count
    stretch <= 5'd8;
    waitv(1, 1'b1, 4000, "drift err");
    stretch <= 5'd0;
    bus(1'b0, `SAI_OFF_STATUS, 32'h0, rv);
    `CHK("status err", 1'b1, rv[0])
    waitv(1, 1'b0, 40000, "drift resync");
    bpf <= 9'd40;
    waitv(1, 1'b1, 12000, "bclk err");
    // Drift flags first; give the bit count five bad frames of its own
    repeat (2400) @(posedge clk);
    bus(1'b0, `SAI_OFF_STATUS, 32'h0, rv);
    `CHK("bclk status", 1'b1, rv[2])
    bpf <= 9'd64;
    waitv(1, 1'b0, 40000, "bclk resync");
    rdchk(`SAI_OFF_STATUS, 32'h0, "status clear");
    $display("test done: clock faults");
    // Master mode clocks from the dividers
    run <= 1'b0;
    bus(1'b1, `SAI_OFF_BDIV, 32'h3, rv);
    bus(1'b1, `SAI_OFF_MASTER, 32'h31, rv);
    @(negedge clk);
    rv[0] = bco;
    for (k = 0; k < 100 && bco === rv[0]; k++) @(negedge clk);
    rv[0] = bco;
    for (k = 0; k < 100 && bco === rv[0]; k++) @(negedge clk);
    `CHK("half period", 3, k)
    `CHK("bit oe", 1'b0, bcoe)
    `CHK("frame oe", 1'b0, fcoe)
    $display("test done: master mode");
    summarize();
  end
endmodule : testbench
